// [src/tcc_regs.svh]
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// Overview of operation
// RULE_01: capcmp bit 2 makes the second register compare (0) or capture (1).
// RULE_02: capcmp bit 0 makes the first register compare (0) or capture (1).
// RULE_03: bit 1 clear: capture on second pin edge; set: first pin opposite edge.
// RULE_04: first pin set to both edges gives no opposite-phase capture.
// RULE_05: outside source holds capture pulses two count clocks longer.
// RULE_06: software stops the timer before config writes, except second invert.
// RULE_07: clear-on-first-match mode never uses the first register as capture.
// RULE_08: output bit 1 lets a first-register match toggle the output flop.
// RULE_09: output bit 4 lets a second-register match toggle the output flop.
// RULE_10: force pair 00 none, 01 clear, 10 set, 11 barred; reads as 0.
// RULE_11: output enable 0 holds the pin low, 1 makes it follow the flop.
// RULE_12: one-shot mode bit; trigger bit fires one shot and self-clears.
// RULE_13: one-shot only with free-running or clear on first pin edge.
// RULE_14: trigger only in one-shot mode, writes two count clocks apart.
// RULE_15: program enables first, force set or reset in a later write.
// RULE_16: second pin edge field: fall, rise, barred, both.
// RULE_17: first pin edge field: fall, rise, barred, both.
// RULE_18: timer 0 clock: divide by 1, 4, 256 or first pin valid edge.
// RULE_19: timer 1 clock: divide by 1, 16, 64; code 11 barred.
// RULE_20: pin used as count clock is not also clear or capture trigger.
// RULE_21: pin high after reset gives one rising edge at first enable only.
// RULE_22: shared pin is second input or timer output, never both.
// RULE_23: counter runs while mode field nonzero, stops and clears at 00.
// RULE_24: unused bits of control registers read 0 and ignore writes.

// register indices; byte address is index times four
`define TCC_IDX_T1_PRESCALE 16'hffb7
`define TCC_IDX_T0_PRESCALE 16'hffbb
`define TCC_IDX_CAPCMP 16'hffbc
`define TCC_IDX_OUTCTL 16'hffbd
`define TCC_IDX_MODE 16'hffba
`define TCC_IDX_COUNTER 16'hff10
`define TCC_IDX_FIRST_CR 16'hff12
`define TCC_IDX_SECOND_CR 16'hff14

`define TCC_RST_CTRL 8'h00
`define TCC_RST_WORD 16'h0000

// writable bit masks
`define TCC_MASK_T1_PRESCALE 8'h03
`define TCC_MASK_T0_PRESCALE 8'hf3
`define TCC_MASK_CAPCMP 8'h07
`define TCC_MASK_OUTCTL 8'h33
`define TCC_MASK_MODE 8'h0e

// capture/compare control fields
`define TCC_CC_FIRST_CAP 0
`define TCC_CC_FIRST_TRIG 1
`define TCC_CC_SECOND_CAP 2
// output control fields
`define TCC_OC_PIN_EN 0
`define TCC_OC_FIRST_INV 1
`define TCC_OC_FORCE_RST 2
`define TCC_OC_FORCE_SET 3
`define TCC_OC_SECOND_INV 4
`define TCC_OC_ONESHOT 5
`define TCC_OC_TRIGGER 6
// mode register fields
`define TCC_MD_OVF 0
`define TCC_MD_EDGE_INV 1

// prescaler shift counts
`define TCC_T0_SHIFT_DIV1 4'd0
`define TCC_T0_SHIFT_DIV4 4'd2
`define TCC_T0_SHIFT_DIV256 4'd8
`define TCC_T1_SHIFT_DIV16 4'd4
`define TCC_T1_SHIFT_DIV64 4'd6
`endif

// [src/tcc_pkg.sv]
package tcc_pkg;
  typedef struct packed {
    logic valid;
    logic opp;
  } tcc_edge_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic seen;
  } tcc_sync_s;

  typedef struct packed {
    logic [7:0] cnt;
  } tcc_pre_s;

  typedef enum logic [2:0] {
    TCC_PH_IDLE = 3'b001,
    TCC_PH_WR = 3'b010,
    TCC_PH_RD = 3'b100
  } tcc_phase_e;

  typedef enum logic [3:0] {
    TCC_R_NONE, TCC_R_T1PS, TCC_R_T0PS, TCC_R_CC, TCC_R_OC,
    TCC_R_MODE, TCC_R_CNT, TCC_R_CR0, TCC_R_CR1
  } tcc_reg_e;

  typedef struct packed {
    tcc_phase_e phase;
    logic hready;
    logic [31:0] hrdata;
    tcc_reg_e sel;
    logic [7:0] ps1;
    logic [7:0] ps0;
    logic [7:0] cc;
    logic [7:0] oc;
    logic [7:0] mode;
    logic [15:0] cnt;
    logic [15:0] cr0;
    logic [15:0] cr1;
    logic outff;
    logic pin;
    logic armed;
    logic t1tick;
  } tcc_top_s;
endpackage

// [src/tcc_edge_det.sv]
`include "tcc_regs.svh"
module tcc_edge_det (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  input wire logic run,
  output tcc_pkg::tcc_edge_s evt
);
  import tcc_pkg::*;
  tcc_sync_s q;
  tcc_sync_s n;
  logic live;
  logic rise;
  logic fall;

  always_comb begin
    n = q;
    n.s1 = pin;
    n.s2 = q.s1;
    // RULE_21 tracking starts at first enable
    live = run | q.seen;
    n.seen = live;
    if (live) begin
      n.prev = q.s2;
    end
    rise = live & q.s2 & ~q.prev;
    fall = live & ~q.s2 & q.prev;
    // RULE_16 RULE_17 edge selection
    case (edge_sel)
      2'b00: evt.valid = fall;
      2'b01: evt.valid = rise;
      2'b11: evt.valid = rise | fall;
      default: evt.valid = 1'b0;
    endcase
    // RULE_04 no opposite edge with both
    case (edge_sel)
      2'b00: evt.opp = rise;
      2'b01: evt.opp = fall;
      default: evt.opp = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  AST_BOTH_NO_OPP: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    edge_sel == 2'b11 |-> !evt.opp)
    else $error("opposite edge reported with both edges selected");
endmodule // tcc_edge_det

// [src/tcc_prescaler.sv]
module tcc_prescaler #(
  parameter int CNT_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic en,
  input wire logic [3:0] shift,
  input wire logic sel_ok,
  output logic tick
);
  import tcc_pkg::*;
  tcc_pre_s q;
  tcc_pre_s n;
  logic [CNT_W-1:0] mask;

  always_comb begin
    n = q;
    mask = CNT_W'((9'h001 << shift) - 9'h001);
    n.cnt = en ? q.cnt + 8'h01 : 8'h00;
    tick = en & sel_ok & ((q.cnt & mask) == mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  AST_DIV_PERIOD: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
    (tick && shift == 4'd2) ##1 (en && shift == 4'd2) [*4]
    |-> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
    else $error("divide by four tick spacing wrong");
endmodule // tcc_prescaler

// [src/tcc_top.sv]
// Chosen here: the AHB-Lite register port.
`include "tcc_regs.svh"
module tcc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic first_input_pin,
  input wire logic second_input_pin,
  output logic timer_output_pin,
  output logic t1_count_tick
);
  import tcc_pkg::*;
  tcc_top_s q;
  tcc_top_s n;
  tcc_edge_s e0;
  tcc_edge_s e1;
  logic run;
  logic pre0_tick;
  logic pre1_tick;
  logic [3:0] t0_shift;
  logic [3:0] t1_shift;
  logic t0_ok;
  logic t1_ok;
  logic tick0;
  logic match0;
  logic match1;
  logic cap0;
  logic cap1;
  logic gate;
  logic toggle;
  logic addr_ph;
  logic wr_now;
  logic wr_oc;
  logic wr_mode;
  logic [7:0] d;

  function automatic tcc_reg_e decode(input logic [31:0] a);
    if (a[31:2] == {14'h0, `TCC_IDX_T1_PRESCALE}) begin
      decode = TCC_R_T1PS;
    end else if (a[31:2] == {14'h0, `TCC_IDX_T0_PRESCALE}) begin
      decode = TCC_R_T0PS;
    end else if (a[31:2] == {14'h0, `TCC_IDX_CAPCMP}) begin
      decode = TCC_R_CC;
    end else if (a[31:2] == {14'h0, `TCC_IDX_OUTCTL}) begin
      decode = TCC_R_OC;
    end else if (a[31:2] == {14'h0, `TCC_IDX_MODE}) begin
      decode = TCC_R_MODE;
    end else if (a[31:2] == {14'h0, `TCC_IDX_COUNTER}) begin
      decode = TCC_R_CNT;
    end else if (a[31:2] == {14'h0, `TCC_IDX_FIRST_CR}) begin
      decode = TCC_R_CR0;
    end else if (a[31:2] == {14'h0, `TCC_IDX_SECOND_CR}) begin
      decode = TCC_R_CR1;
    end else begin
      decode = TCC_R_NONE;
    end
  endfunction

  function automatic logic [31:0] rd_mux(input tcc_top_s s);
    case (s.sel)
      TCC_R_T1PS: rd_mux = {24'h0, s.ps1};
      TCC_R_T0PS: rd_mux = {24'h0, s.ps0};
      TCC_R_CC: rd_mux = {24'h0, s.cc};
      TCC_R_OC: rd_mux = {24'h0, s.oc};
      TCC_R_MODE: rd_mux = {24'h0, s.mode};
      TCC_R_CNT: rd_mux = {16'h0, s.cnt};
      TCC_R_CR0: rd_mux = {16'h0, s.cr0};
      TCC_R_CR1: rd_mux = {16'h0, s.cr1};
      default: rd_mux = 32'h0;
    endcase
  endfunction

  // RULE_23 run while mode field nonzero
  assign run = q.mode[3:2] != 2'b00;

  tcc_edge_det u_edge_first (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(first_input_pin),
    .edge_sel(q.ps0[5:4]),
    .run(run),
    .evt(e0)
  );

  tcc_edge_det u_edge_second (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(second_input_pin),
    .edge_sel(q.ps0[7:6]),
    .run(run),
    .evt(e1)
  );

  // RULE_18 timer 0 clock select
  always_comb begin
    t0_ok = 1'b1;
    case (q.ps0[1:0])
      2'b00: t0_shift = `TCC_T0_SHIFT_DIV1;
      2'b01: t0_shift = `TCC_T0_SHIFT_DIV4;
      2'b10: t0_shift = `TCC_T0_SHIFT_DIV256;
      default: begin
        t0_shift = `TCC_T0_SHIFT_DIV1;
        t0_ok = 1'b0;
      end
    endcase
    // RULE_19 timer 1 clock select
    t1_ok = 1'b1;
    case (q.ps1[1:0])
      2'b00: t1_shift = `TCC_T0_SHIFT_DIV1;
      2'b01: t1_shift = `TCC_T1_SHIFT_DIV16;
      2'b10: t1_shift = `TCC_T1_SHIFT_DIV64;
      default: begin
        t1_shift = `TCC_T0_SHIFT_DIV1;
        t1_ok = 1'b0;
      end
    endcase
  end

  tcc_prescaler #(.CNT_W(8)) u_pre0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(run),
    .shift(t0_shift),
    .sel_ok(t0_ok),
    .tick(pre0_tick)
  );

  tcc_prescaler #(.CNT_W(8)) u_pre1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(1'b1),
    .shift(t1_shift),
    .sel_ok(t1_ok),
    .tick(pre1_tick)
  );

  always_comb begin
    n = q;
    d = hwdata[7:0];
    addr_ph = hready & hsel & htrans[1];
    wr_now = q.phase == TCC_PH_WR;
    wr_oc = wr_now & (q.sel == TCC_R_OC);
    wr_mode = wr_now & (q.sel == TCC_R_MODE);
    // bus data phase and next address phase
    if (q.phase == TCC_PH_RD) begin
      n.hrdata = rd_mux(q);
      n.hready = 1'b1;
      n.phase = TCC_PH_IDLE;
    end else if (addr_ph) begin
      n.sel = decode(haddr);
      n.phase = hwrite ? TCC_PH_WR : TCC_PH_RD;
      n.hready = hwrite;
    end else begin
      n.phase = TCC_PH_IDLE;
    end

    tick0 = (q.ps0[1:0] == 2'b11) ? e0.valid : pre0_tick;
    // RULE_02 RULE_08 first register compare match
    match0 = run & tick0 & ~q.cc[`TCC_CC_FIRST_CAP] & (q.cnt == q.cr0);
    // RULE_01 RULE_09 second register compare match
    match1 = run & tick0 & ~q.cc[`TCC_CC_SECOND_CAP] & (q.cnt == q.cr1);
    // RULE_03 first register capture trigger
    cap0 = run & q.cc[`TCC_CC_FIRST_CAP]
      & (q.cc[`TCC_CC_FIRST_TRIG] ? e0.opp : e1.valid);
    cap1 = run & q.cc[`TCC_CC_SECOND_CAP] & e0.valid;

    // RULE_23 counter stop, clear and count
    if (!run) begin
      n.cnt = `TCC_RST_WORD;
    end else if (q.mode[3:2] == 2'b10 && e0.valid) begin
      n.cnt = `TCC_RST_WORD;
    end else if (tick0) begin
      if (q.mode[3:2] == 2'b11 && q.cnt == q.cr0) begin
        n.cnt = `TCC_RST_WORD;
      end else begin
        n.cnt = q.cnt + 16'h0001;
      end
    end

    // RULE_12 one-shot gating
    gate = ~q.oc[`TCC_OC_ONESHOT] | q.armed;
    // RULE_08 RULE_09 inversion enables
    toggle = gate & ((match0 & q.oc[`TCC_OC_FIRST_INV])
      ^ (match1 & q.oc[`TCC_OC_SECOND_INV])
      ^ (run & q.mode[`TCC_MD_EDGE_INV] & e0.valid));
    n.outff = q.outff ^ toggle;
    if (match0 & q.armed) begin
      n.armed = 1'b0;
    end
    if (q.oc[`TCC_OC_ONESHOT] && q.mode[3:2] == 2'b10 && e0.valid) begin
      n.armed = 1'b1;
    end

    // register writes; overflow and captures applied after
    if (wr_now) begin
      case (q.sel)
        // RULE_24 unused bits dropped on write
        TCC_R_T1PS: n.ps1 = d & `TCC_MASK_T1_PRESCALE;
        TCC_R_T0PS: n.ps0 = d & `TCC_MASK_T0_PRESCALE;
        TCC_R_CC: n.cc = d & `TCC_MASK_CAPCMP;
        TCC_R_OC: begin
          n.oc = d & `TCC_MASK_OUTCTL;
          // RULE_10 force set and clear
          if (d[`TCC_OC_FORCE_SET] && !d[`TCC_OC_FORCE_RST]) begin
            n.outff = 1'b1;
          end else if (!d[`TCC_OC_FORCE_SET] && d[`TCC_OC_FORCE_RST]) begin
            n.outff = 1'b0;
          end
          // RULE_12 software trigger arms one shot
          if (d[`TCC_OC_TRIGGER]) begin
            n.armed = 1'b1;
          end
        end
        TCC_R_MODE: n.mode = (d & `TCC_MASK_MODE)
          | {7'h0, q.mode[`TCC_MD_OVF] & d[`TCC_MD_OVF]};
        TCC_R_CR0: n.cr0 = hwdata[15:0];
        TCC_R_CR1: n.cr1 = hwdata[15:0];
        default: n.cnt = n.cnt;
      endcase
    end
    // overflow set wins over clear
    if (run && tick0 && q.cnt == 16'hffff) begin
      n.mode[`TCC_MD_OVF] = 1'b1;
    end
    // RULE_02 RULE_03 capture into first register
    if (cap0) begin
      n.cr0 = q.cnt;
    end
    // RULE_01 capture into second register
    if (cap1) begin
      n.cr1 = q.cnt;
    end
    // RULE_11 pin low unless enabled
    n.pin = n.oc[`TCC_OC_PIN_EN] & n.outff;
    n.t1tick = pre1_tick;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.phase <= TCC_PH_IDLE;
      q.hready <= 1'b1;
      q.sel <= TCC_R_NONE;
    end else begin
      q <= n;
    end
  end

  assign hreadyout = q.hready;
  assign hrdata = q.hrdata;
  assign hresp = 1'b0;
  assign timer_output_pin = q.pin;
  assign t1_count_tick = q.t1tick;

  AST_PIN_LOW: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
    !q.oc[`TCC_OC_PIN_EN] |-> !timer_output_pin)
    else $error("output pin high while disabled");

  AST_FORCE_SET: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
    (wr_oc && hwdata[3:2] == 2'b10) |=> q.outff && q.oc[3:2] == 2'b00)
    else $error("force set did not set output flop");

  AST_FORCE_CLR: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
    (wr_oc && hwdata[3:2] == 2'b01) |=> !q.outff)
    else $error("force reset did not clear output flop");

  AST_TRIG_READ0: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
    (wr_oc && hwdata[6]) |=> q.armed && !q.oc[6])
    else $error("one-shot trigger not armed or not self-cleared");

  AST_STOP_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_23
    (!run && !wr_mode) |=> q.cnt == 16'h0000)
    else $error("stopped counter not cleared");

  AST_CAP_FIRST: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    cap0 |=> q.cr0 == $past(q.cnt))
    else $error("first register capture lost");

  AST_CAP_SECOND: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    cap1 |=> q.cr1 == $past(q.cnt))
    else $error("second register capture lost");

  AST_HOLD_FLOP: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
    (!q.oc[1] && !q.oc[4] && !q.mode[1] && !wr_oc)
    |=> q.outff == $past(q.outff))
    else $error("output flop changed with inversion disabled");

  AST_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
    (match1 && q.oc[4] && !q.oc[5] && !(match0 && q.oc[1]) && !q.mode[1]
      && !wr_oc) |=> q.outff != $past(q.outff))
    else $error("second match did not toggle output flop");

  AST_UNUSED0: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_24
    wr_now |=> (q.cc[7:3] == 5'h00) && (q.ps1[7:2] == 6'h00))
    else $error("unused control bits not zero");

  AST_RD_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ph && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule // tcc_top

// [testbench/tcc_pin_src.sv]
module tcc_pin_src #(
  parameter int HOLD = 4
) (
  input wire logic hclk,
  input wire logic timer_output_pin,
  output logic first_input_pin,
  output logic second_input_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    first_input_pin = 1'b0;
    second_input_pin = 1'b0;
  end

  task automatic drive(input logic sec, input logic lvl);
    @(posedge hclk);
    if (sec) begin
      second_input_pin <= lvl;
    end else begin
      first_input_pin <= lvl;
    end
    repeat (HOLD) @(posedge hclk);
  endtask

  // output load: cycles between two output toggles
  task automatic gap(output int n);
    logic v;
    int k;
    k = 0;
    v = timer_output_pin;
    while (timer_output_pin === v && k < 5000) begin
      @(posedge hclk);
      k++;
    end
    v = timer_output_pin;
    n = 0;
    while (timer_output_pin === v && n < 5000) begin
      @(posedge hclk);
      n++;
    end
  endtask
endmodule // tcc_pin_src

// [testbench/tcc_top_tb.sv]
`include "tcc_regs.svh"
module tcc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tcc_pkg::*;
  localparam logic [31:0] A_T1 = {14'h0, `TCC_IDX_T1_PRESCALE, 2'b00};
  localparam logic [31:0] A_T0 = {14'h0, `TCC_IDX_T0_PRESCALE, 2'b00};
  localparam logic [31:0] A_CC = {14'h0, `TCC_IDX_CAPCMP, 2'b00};
  localparam logic [31:0] A_OC = {14'h0, `TCC_IDX_OUTCTL, 2'b00};
  localparam logic [31:0] A_MD = {14'h0, `TCC_IDX_MODE, 2'b00};
  localparam logic [31:0] A_CNT = {14'h0, `TCC_IDX_COUNTER, 2'b00};
  localparam logic [31:0] A_CR0 = {14'h0, `TCC_IDX_FIRST_CR, 2'b00};
  localparam logic [31:0] A_CR1 = {14'h0, `TCC_IDX_SECOND_CR, 2'b00};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic timer_output_pin, t1_count_tick, first_input_pin, second_input_pin;
  logic [31:0] at[4] = '{A_T1, A_T0, A_CC, A_OC};
  logic [7:0] mk[4] = '{8'h03, 8'hf3, 8'h07, 8'h33};
  logic [7:0] ow[6] = '{8'h01, 8'h09, 8'h0d, 8'h05, 8'h09, 8'h00};
  logic ov[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  int dv[3] = '{1, 4, 256};
  int tk[4] = '{1, 16, 64, 200};
  int n_errors, compares, g;

  tcc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .first_input_pin(first_input_pin),
    .second_input_pin(second_input_pin),
    .timer_output_pin(timer_output_pin), .t1_count_tick(t1_count_tick));
  tcc_pin_src i_src (.hclk(hclk), .timer_output_pin(timer_output_pin),
    .first_input_pin(first_input_pin), .second_input_pin(second_input_pin));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // address phase held until accepted
  task automatic ap(input logic [31:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
  endtask

  task automatic wr(input logic [31:0] a, dat);
    ap(a, 1'b1);
    hwdata <= dat;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] dat);
    ap(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    dat = hrdata;
  endtask

  task automatic rc(input logic [31:0] a, exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // captured means the sentinel was overwritten
  task automatic capd(input logic [31:0] a, input logic ex);
    logic [31:0] v;
    rd(a, v);
    chk({31'h0, v[15:0] !== 16'hffff}, {31'h0, ex});
  endtask

  task automatic cap(input logic [7:0] cc, ps, input logic r1, sec, lvl, ex);
    logic [31:0] a;
    a = r1 ? A_CR1 : A_CR0;
    i_src.drive(sec, !lvl);
    wr(A_MD, 32'h0);
    wr(A_OC, 32'h0);
    wr(A_CC, {24'h0, cc});
    wr(A_T0, {24'h0, ps});
    wr(a, 32'hffff);
    wr(A_MD, 32'h04);
    i_src.drive(sec, lvl);
    repeat (4) @(posedge hclk);
    capd(a, ex);
  endtask

  task automatic tick_gap(output int n);
    int k;
    k = 0;
    // skip ticks still launched under the old divider
    repeat (2) @(posedge hclk);
    while (t1_count_tick !== 1'b1 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (t1_count_tick !== 1'b1 && n < 200);
  endtask

  task automatic complete_run();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    complete_run();
  end

  initial begin
    n_errors = 0;
    compares = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      rc(at[i], 32'h0);
      wr(at[i], 32'hffffffff);
      rc(at[i], {24'h0, mk[i]});
      wr(at[i], 32'h0);
    end
    wr(32'h100, 32'hffffffff);
    rc(32'h100, 32'h0);
    wr(A_CNT, 32'h1234);
    rc(A_CNT, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(A_OC, {24'h0, ow[i]});
      @(posedge hclk);
      chk({31'h0, timer_output_pin}, {31'h0, ov[i]});
    end
    for (int c = 0; c < 3; c++) begin
      wr(A_MD, 32'h0);
      wr(A_T0, c);
      wr(A_CR0, 32'h3);
      wr(A_OC, 32'h03);
      wr(A_MD, 32'h0c);
      i_src.gap(g);
      chk(32'(g), 32'(4 * dv[c]));
    end
    wr(A_MD, 32'h0);
    rc(A_CNT, 32'h0);
    wr(A_T0, 32'h0);
    wr(A_CR0, 32'h5);
    wr(A_CR1, 32'h2);
    wr(A_OC, 32'h11);
    wr(A_MD, 32'h0c);
    i_src.gap(g);
    chk(32'(g), 32'd6);
    for (int c = 0; c < 4; c++) begin
      wr(A_T1, c);
      tick_gap(g);
      chk(32'(g), 32'(tk[c]));
    end
    cap(8'h04, 8'h10, 1'b1, 1'b0, 1'b1, 1'b1);
    cap(8'h04, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
    cap(8'h04, 8'h20, 1'b1, 1'b0, 1'b1, 1'b0);
    cap(8'h04, 8'h30, 1'b1, 1'b0, 1'b1, 1'b1);
    cap(8'h04, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
    cap(8'h04, 8'h30, 1'b1, 1'b0, 1'b0, 1'b1);
    cap(8'h04, 8'h10, 1'b1, 1'b0, 1'b0, 1'b0);
    cap(8'h00, 8'h10, 1'b1, 1'b0, 1'b1, 1'b0);
    cap(8'h01, 8'h40, 1'b0, 1'b1, 1'b1, 1'b1);
    cap(8'h01, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0);
    cap(8'h01, 8'h80, 1'b0, 1'b1, 1'b1, 1'b0);
    cap(8'h01, 8'hc0, 1'b0, 1'b1, 1'b0, 1'b1);
    cap(8'h03, 8'h10, 1'b0, 1'b0, 1'b0, 1'b1);
    cap(8'h03, 8'h10, 1'b0, 1'b0, 1'b1, 1'b0);
    cap(8'h03, 8'h30, 1'b0, 1'b0, 1'b0, 1'b0);
    cap(8'h02, 8'h10, 1'b0, 1'b0, 1'b0, 1'b0);
    // first pin rising edges as the count clock
    wr(A_MD, 32'h0);
    wr(A_T0, 32'h13);
    wr(A_MD, 32'h04);
    repeat (3) begin
      i_src.drive(1'b0, 1'b1);
      i_src.drive(1'b0, 1'b0);
    end
    rc(A_CNT, 32'h3);
    wr(A_MD, 32'h0);
    wr(A_CC, 32'h0);
    wr(A_T0, 32'h0);
    wr(A_CR0, 32'd20);
    wr(A_OC, 32'h23);
    wr(A_OC, 32'h27);
    wr(A_MD, 32'h04);
    repeat (40) @(posedge hclk);
    chk({31'h0, timer_output_pin}, 32'h0);
    wr(A_MD, 32'h0);
    wr(A_OC, 32'h63);
    wr(A_MD, 32'h04);
    repeat (40) @(posedge hclk);
    chk({31'h0, timer_output_pin}, 32'h1);
    rc(A_OC, 32'h23);
    i_src.drive(1'b0, 1'b1);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(A_T0, 32'h10);
    wr(A_CC, 32'h04);
    wr(A_CR1, 32'hffff);
    wr(A_MD, 32'h04);
    repeat (8) @(posedge hclk);
    capd(A_CR1, 1'b1);
    wr(A_MD, 32'h0);
    wr(A_CR1, 32'hffff);
    wr(A_MD, 32'h04);
    repeat (8) @(posedge hclk);
    capd(A_CR1, 1'b0);
    complete_run();
  end
endmodule // tcc_top_tb
